// >>> translation_unit_consts.svh
// offsets, field positions, reset values and timing counts of the translation unit
// assumes inclusion by bare name from the design module and the bench
`ifndef TRANSLATION_UNIT_CONSTS_SVH
`define TRANSLATION_UNIT_CONSTS_SVH
`define ADDR_SUP_SEL 8'h00
`define ADDR_USR_SEL 8'h04
`define ADDR_INT_STATUS 8'h08
`define ADDR_INT_MASK 8'h0c
`define ADDR_SEG_INDEX 8'h10
`define ADDR_SEG_DATA 8'h14
`define ADDR_PAGE_INDEX 8'h18
`define ADDR_PAGE_DATA 8'h1c
`define SEL_RESET 3'h0
`define MASK_RESET 3'h0
`define PTE_VALID 31
`define PTE_PROT_HI 30
`define PTE_PROT_LO 25
`define PTE_ACC 24
`define PTE_MOD 23
`define PTE_PPN_HI 11
`define EV_FAULT 0
`define EV_PARITY 1
`define EV_TIMEOUT 2
`define CLOCK_NS 50
`define TIMEOUT_NS 10000
`define TIMEOUT_CYCLES ((`TIMEOUT_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// >>> translation_unit_pkg.sv
// types of the translation unit: controller states and cycle class codes
// assumes nothing of its surroundings
`default_nettype none
package translation_unit_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEGRD = 3'b001,
    ST_PGRD = 3'b010,
    ST_CHECK = 3'b011,
    ST_WAIT = 3'b100
  } state_t;
  typedef enum logic [2:0] {
    CC_USER_DATA = 3'b001,
    CC_USER_PROG = 3'b010,
    CC_SUP_DATA = 3'b101,
    CC_SUP_PROG = 3'b110,
    CC_CPU_SPACE = 3'b111
  } cycle_class_t;
endpackage
`default_nettype wire

// >>> translation_unit.sv
// two-level context/segment/page translation and protection unit
// assumes processor and memory logic on CLOCK; registers over a plain strobe port
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "translation_unit_consts.svh"

// Functional notes
// R1: eight contexts exist, the current one taken from one of two 3-bit selector registers.
// R2: supervisor cycles take the supervisor selector, user cycles the user selector.
// R3: privilege and cycle type are decoded from the three cycle class code inputs.
// R4: the segment map has 4096 entries, one eighth of them per context.
// R5: a segment entry is 8 bits wide and names one page group.
// R6: the page map has 4096 entries, each mapping one 2K byte page.
// R7: the page map is 256 groups of 16 entries, the group chosen by the segment entry.
// R8: each page entry is a 32-bit word of physical page number and page attributes.
// R9: a 6-bit protection field of supervisor and user read, write, execute gates each access; CPU space cycles bypass it.
// R10: an access sets the page's accessed bit and a write also sets its modified bit.
// R11: invalid pages, denied accesses and cycles aborted by a prior parity error leave them alone.
// R12: all other cycles except CPU space cycles update them, even those ending in parity error or timeout.
// R13: segment index is context plus upper address bits, page index is group plus page bits.
// R14: invalid or denied accesses end with a bus error instead of a memory cycle.
module translation_unit #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  input wire logic CYC_REQ,
  input wire logic [23:0] CYC_VADDR,
  input wire logic [2:0] CYCLE_CLASS_CODE,
  input wire logic CYC_WRITE,
  output logic CYC_ACK,
  output logic CYC_BERR,
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic [22:0] MEM_ADDR,
  input wire logic MEM_DONE,
  input wire logic MEM_PARITY_ERR
);
  localparam int MAX_CYCLE = TIMEOUT_CYCLES + 8;

  logic [7:0] seg_map [4096];
  logic [31:0] page_map [4096];
  translation_unit_pkg::state_t state_reg;
  logic [2:0] sup_sel_reg, usr_sel_reg, status_reg, mask_reg;
  logic [11:0] seg_index_reg, page_index_reg, seg_idx_reg, pg_idx_reg;
  logic [7:0] seg_q;
  logic [31:0] pte_q;
  logic [23:0] vaddr_reg;
  logic [2:0] class_reg;
  logic write_reg, abort_reg;
  logic [15:0] timer_reg;
  logic [2:0] events, rights, need;
  logic sw_page_wr, sw_seg_wr, stall;
  logic cls_sup, cls_prog, cls_cpu, cls_ok;
  logic permit, chk, fault, go, stat_we;
  logic [31:0] stat_wdata;

  assign sw_page_wr = REG_WR && (REG_ADDR == `ADDR_PAGE_DATA);
  assign sw_seg_wr = REG_WR && (REG_ADDR == `ADDR_SEG_DATA);
  // software page writes share the map's only write port, so the check waits a cycle
  assign stall = sw_page_wr;

  // privilege from the top code bit, then program or data fetch
  assign cls_sup = class_reg[2]; // R3
  assign cls_cpu = class_reg == translation_unit_pkg::CC_CPU_SPACE; // R3
  assign cls_prog = (class_reg == translation_unit_pkg::CC_USER_PROG) ||
                    (class_reg == translation_unit_pkg::CC_SUP_PROG); // R3
  assign cls_ok = cls_prog || (class_reg == translation_unit_pkg::CC_USER_DATA) ||
                  (class_reg == translation_unit_pkg::CC_SUP_DATA);

  // protection field is {sup r,w,x, user r,w,x}
  assign rights = cls_sup ? pte_q[`PTE_PROT_HI -: 3] : pte_q[`PTE_PROT_LO + 2 -: 3]; // R9
  assign need = cls_prog ? 3'h1 : (write_reg ? 3'h2 : 3'h4); // R9
  assign permit = cls_ok && ((rights & need) != 3'h0); // R9

  assign chk = (state_reg == translation_unit_pkg::ST_CHECK) && !stall;
  assign fault = chk && !abort_reg && !cls_cpu && !(pte_q[`PTE_VALID] && permit); // R14
  assign go = chk && !abort_reg && !fault;
  assign stat_we = go && !cls_cpu; // R10 R11 R12
  assign stat_wdata = pte_q | (32'h1 << `PTE_ACC) | ({31'h0, write_reg} << `PTE_MOD); // R10

  assign events = {
    (state_reg == translation_unit_pkg::ST_WAIT) && !MEM_DONE && (timer_reg == 16'h0),
    (state_reg == translation_unit_pkg::ST_WAIT) && MEM_DONE && MEM_PARITY_ERR,
    fault
  };

  always_ff @(posedge CLOCK)
  begin
    if (sw_seg_wr)
      seg_map[seg_index_reg] <= REG_WDATA[7:0]; // R4 R5
  end

  always_ff @(posedge CLOCK)
  begin
    if (sw_page_wr)
      page_map[page_index_reg] <= REG_WDATA; // R6 R8
    else if (stat_we)
      page_map[pg_idx_reg] <= stat_wdata; // R10 R12
  end

  // the entry comes straight from the fresh group pointer, so the check sees it
  always_ff @(posedge CLOCK)
  begin
    seg_q <= seg_map[seg_idx_reg];
    pte_q <= page_map[(state_reg == translation_unit_pkg::ST_PGRD) ?
                      {seg_q, vaddr_reg[14:11]} : pg_idx_reg]; // R7 R13
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sup_sel_reg <= `SEL_RESET;
      usr_sel_reg <= `SEL_RESET;
      mask_reg <= `MASK_RESET;
      seg_index_reg <= 12'h000;
      page_index_reg <= 12'h000;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        `ADDR_SUP_SEL: sup_sel_reg <= REG_WDATA[2:0]; // R1
        `ADDR_USR_SEL: usr_sel_reg <= REG_WDATA[2:0]; // R1
        `ADDR_INT_MASK: mask_reg <= REG_WDATA[2:0];
        `ADDR_SEG_INDEX: seg_index_reg <= REG_WDATA[11:0];
        `ADDR_PAGE_INDEX: page_index_reg <= REG_WDATA[11:0];
        default: ;
      endcase
    end
  end

  // a new event in the reading cycle survives the clear
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      status_reg <= 3'h0;
    else if (REG_RD && (REG_ADDR == `ADDR_INT_STATUS))
      status_reg <= events;
    else
      status_reg <= status_reg | events;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      IRQ <= 1'b0;
    else
      IRQ <= (status_reg & mask_reg) != 3'h0;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      REG_RDATA <= 32'h0;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        `ADDR_SUP_SEL: REG_RDATA <= {29'h0, sup_sel_reg};
        `ADDR_USR_SEL: REG_RDATA <= {29'h0, usr_sel_reg};
        `ADDR_INT_STATUS: REG_RDATA <= {29'h0, status_reg};
        `ADDR_INT_MASK: REG_RDATA <= {29'h0, mask_reg};
        `ADDR_SEG_INDEX: REG_RDATA <= {20'h0, seg_index_reg};
        `ADDR_SEG_DATA: REG_RDATA <= {24'h0, seg_map[seg_index_reg]};
        `ADDR_PAGE_INDEX: REG_RDATA <= {20'h0, page_index_reg};
        `ADDR_PAGE_DATA: REG_RDATA <= page_map[page_index_reg];
        default: REG_RDATA <= 32'h0;
      endcase
    end
    else
      REG_RDATA <= 32'h0;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= translation_unit_pkg::ST_IDLE;
      vaddr_reg <= 24'h0;
      class_reg <= 3'h0;
      write_reg <= 1'b0;
      seg_idx_reg <= 12'h000;
      pg_idx_reg <= 12'h000;
      timer_reg <= 16'h0;
    end
    else
    begin
      case (state_reg)
        translation_unit_pkg::ST_IDLE:
          if (CYC_REQ)
          begin
            vaddr_reg <= CYC_VADDR;
            class_reg <= CYCLE_CLASS_CODE;
            write_reg <= CYC_WRITE;
            seg_idx_reg <= {CYCLE_CLASS_CODE[2] ? sup_sel_reg : usr_sel_reg,
                            CYC_VADDR[23:15]}; // R1 R2 R13
            state_reg <= translation_unit_pkg::ST_SEGRD;
          end
        translation_unit_pkg::ST_SEGRD:
          state_reg <= translation_unit_pkg::ST_PGRD;
        translation_unit_pkg::ST_PGRD:
        begin
          pg_idx_reg <= {seg_q, vaddr_reg[14:11]}; // R7 R13
          state_reg <= translation_unit_pkg::ST_CHECK;
        end
        translation_unit_pkg::ST_CHECK:
          if (go)
          begin
            timer_reg <= 16'(TIMEOUT_CYCLES);
            state_reg <= translation_unit_pkg::ST_WAIT;
          end
          else if (chk)
            state_reg <= translation_unit_pkg::ST_IDLE;
        translation_unit_pkg::ST_WAIT:
          if (MEM_DONE || (timer_reg == 16'h0))
            state_reg <= translation_unit_pkg::ST_IDLE;
          else
            timer_reg <= timer_reg - 16'h1;
        default:
          state_reg <= translation_unit_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      MEM_REQ <= 1'b0;
      MEM_WRITE <= 1'b0;
      MEM_ADDR <= 23'h0;
    end
    else
    begin
      MEM_REQ <= go;
      if (go)
      begin
        MEM_WRITE <= write_reg;
        MEM_ADDR <= cls_cpu ? vaddr_reg[22:0] :
                    {pte_q[`PTE_PPN_HI:0], vaddr_reg[10:0]}; // R6 R8
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CYC_ACK <= 1'b0;
      CYC_BERR <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      CYC_ACK <= (state_reg == translation_unit_pkg::ST_WAIT) && MEM_DONE;
      CYC_BERR <= (chk && (abort_reg || fault)) || events[`EV_TIMEOUT]; // R11 R14
      if (events[`EV_PARITY])
        abort_reg <= 1'b1; // R11
      else if (chk)
        abort_reg <= 1'b0;
    end
  end

  sequence s_fault;
    chk && fault;
  endsequence
  sequence s_berr_only;
    CYC_BERR && !MEM_REQ && !CYC_ACK;
  endsequence

  property p_context;
    @(posedge CLOCK) disable iff (!RESETN)
    (state_reg == translation_unit_pkg::ST_IDLE) && CYC_REQ |=>
      seg_idx_reg[11:9] == ($past(CYCLE_CLASS_CODE[2]) ? $past(sup_sel_reg) : $past(usr_sel_reg));
  endproperty
  a_context: assert property (p_context) else $error("wrong context selector"); // R2

  property p_fault_berr;
    @(posedge CLOCK) disable iff (!RESETN)
    s_fault |=> s_berr_only ##1 (state_reg == translation_unit_pkg::ST_IDLE);
  endproperty
  a_fault_berr: assert property (p_fault_berr) else $error("fault did not bus error"); // R14

  property p_no_stat_on_fault;
    @(posedge CLOCK) disable iff (!RESETN)
    chk && (abort_reg || !pte_q[`PTE_VALID] || !permit) && !cls_cpu |=>
      page_map[$past(pg_idx_reg)] == $past(page_map[pg_idx_reg]);
  endproperty
  a_no_stat_on_fault: assert property (p_no_stat_on_fault) else $error("stats touched"); // R11

  property p_stat_bits;
    @(posedge CLOCK) disable iff (!RESETN)
    stat_we |=> page_map[$past(pg_idx_reg)][`PTE_ACC] &&
      (page_map[$past(pg_idx_reg)][`PTE_MOD] == ($past(write_reg) || $past(pte_q[`PTE_MOD])));
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("accessed or modified wrong"); // R10

  property p_stat_before_mem;
    @(posedge CLOCK) disable iff (!RESETN)
    MEM_REQ && !cls_cpu |-> $past(stat_we);
  endproperty
  a_stat_before_mem: assert property (p_stat_before_mem) else $error("stats not updated"); // R12

  property p_abort;
    @(posedge CLOCK) disable iff (!RESETN)
    chk && abort_reg |=> CYC_BERR && !abort_reg && !MEM_REQ;
  endproperty
  a_abort: assert property (p_abort) else $error("parity abort missed"); // R11

  property p_page_index;
    @(posedge CLOCK) disable iff (!RESETN)
    state_reg == translation_unit_pkg::ST_PGRD |=>
      pg_idx_reg == {$past(seg_q), vaddr_reg[14:11]};
  endproperty
  a_page_index: assert property (p_page_index) else $error("page index wrong"); // R13

  property p_cycle_ends;
    @(posedge CLOCK) disable iff (!RESETN)
    (state_reg == translation_unit_pkg::ST_IDLE) && CYC_REQ && !REG_WR |->
      ##[4:MAX_CYCLE] (CYC_ACK || CYC_BERR);
  endproperty
  a_cycle_ends: assert property (p_cycle_ends) else $error("cycle never ended"); // R12

  property p_irq;
    @(posedge CLOCK) disable iff (!RESETN)
    ##1 IRQ == ($past(status_reg & mask_reg) != 3'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// >>> mem_partner.sv
// memory system stand-in: answers each memory request after a chosen delay, or never while hang is set
// assumes one-cycle request pulses on the shared clock
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic [2:0] delay,
  input wire logic parity,
  input wire logic hang,
  output logic done,
  output logic parity_err
);
  initial
  begin
    done = 1'h0;
    parity_err = 1'h1;
  end
  // parity line carries the inverse outside done, so early sampling shows up
  always @(posedge clk)
  begin
    if (mem_req && !hang)
    begin
      repeat (delay) @(posedge clk);
      done <= 1'h1;
      parity_err <= parity;
      @(posedge clk);
      done <= 1'h0;
      parity_err <= !parity;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the translation unit against an array model
// assumes the memory partner and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "translation_unit_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  localparam logic [2:0] codes [8] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0, 3'h3, 3'h4, 3'h7};
  localparam logic [7:0] rst_regs [5] = '{`ADDR_SUP_SEL, `ADDR_USR_SEL, `ADDR_INT_STATUS,
    `ADDR_INT_MASK, 8'hfc};
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, req = 1'h0, cwr = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] va = 24'h0;
  logic [2:0] cc = 3'h1, dly = 3'h0;
  logic irq, ack, berr, mreq, mwr, done, perr, par = 1'h0, hang = 1'h0;
  logic [22:0] maddr;
  int num_errors = 0, checks = 0, seed = 64;
  logic [31:0] pg_m [int];
  logic [7:0] seg_m [int];
  always #25 clk = ~clk;
  translation_unit #(.TIMEOUT_CYCLES(8)) u_translation_unit (.CLOCK(clk), .RESETN(rst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .IRQ(irq), .CYC_REQ(req), .CYC_VADDR(va), .CYCLE_CLASS_CODE(cc), .CYC_WRITE(cwr),
    .CYC_ACK(ack), .CYC_BERR(berr), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_ADDR(maddr),
    .MEM_DONE(done), .MEM_PARITY_ERR(perr));
  mem_partner u_mem_partner (.clk(clk), .mem_req(mreq), .delay(dly), .parity(par),
    .hang(hang), .done(done), .parity_err(perr));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // strobe dropped and one edge let pass, so back-to-back calls never collide
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  initial
  begin
    logic [31:0] d, e;
    logic [23:0] v;
    logic [11:0] si, pi;
    logic [2:0] c, ss, us, ctx, m, est;
    logic ok, ab, a1, b1, mq, mw1, w, prog, xl;
    logic [22:0] ma;
    int lat, n, b, i, r;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    reg_wr(8'hfc, 32'hffffffff);
    foreach (rst_regs[j])
    begin
      reg_rd(rst_regs[j], d);
      `CHK(d, 32'h0)
    end
    ab = 1'h0;
    for (i = 0; i < 60; i++)
    begin
      r = $random(seed);
      ss = r[2:0];
      us = r[5:3];
      c = ab ? 3'h5 : codes[r[8:6]];
      prog = c[1:0] == 2'h2;
      w = r[9] && !prog;
      xl = c inside {3'h1, 3'h2, 3'h5, 3'h6};
      reg_wr(`ADDR_SUP_SEL, {29'h0, ss});
      reg_wr(`ADDR_USR_SEL, {29'h0, us});
      r = $random(seed);
      // few segments per context, so a wrong context or index reads stale entries
      v = {r[23], 6'h0, r[16:0]};
      ctx = c[2] ? ss : us;
      si = {ctx, v[23:15]};
      seg_m[si] = r[31:24];
      pi = {seg_m[si], v[14:11]};
      r = $random(seed);
      e = {r[31] | r[30], r[30:23], 11'h0, r[11:0]};
      pg_m[pi] = e;
      reg_wr(`ADDR_SEG_INDEX, {20'h0, si});
      reg_wr(`ADDR_SEG_DATA, {24'h0, seg_m[si]});
      reg_wr(`ADDR_PAGE_INDEX, {20'h0, pi});
      reg_wr(`ADDR_PAGE_DATA, e);
      r = $random(seed);
      m = r[2:0] & {2'h3, !ab};
      reg_wr(`ADDR_INT_MASK, {29'h0, m});
      par <= r[5:3] == 3'h0;
      hang <= r[5:3] == 3'h1;
      dly <= r[8:6];
      req <= 1'h1;
      cc <= c;
      cwr <= w;
      va <= v;
      @(posedge clk);
      req <= 1'h0;
      a1 = 1'h0;
      b1 = 1'h0;
      mq = 1'h0;
      lat = -1;
      for (n = 0; n < 100 && !a1 && !b1; n++)
      begin
        #1;
        if ((mreq || berr) && lat < 0)
          lat = n;
        if (mreq)
        begin
          mq = 1'h1;
          ma = maddr;
          mw1 = mwr;
        end
        a1 = ack;
        b1 = berr;
        @(posedge clk);
      end
      if (!a1 && !b1)
      begin
        num_errors++;
        tally_and_finish();
      end
      b = (c[2] ? 30 : 27) - (prog ? 2 : int'(w));
      ok = !ab && (c == 3'h7 || (xl && e[31] && e[b]));
      `CHK(lat, 3)
      `CHK(mq, ok)
      `CHK(a1, ok && !hang)
      `CHK(b1, !ok || hang)
      if (ok)
      begin
        `CHK(ma, c == 3'h7 ? v[22:0] : {e[11:0], v[10:0]})
        `CHK(mw1, w)
      end
      if (ok && xl)
        pg_m[pi] = e | {7'h0, 1'h1, w, 23'h0};
      est = {ok && hang, ok && par && !hang, !ok && !ab};
      reg_wr(`ADDR_PAGE_INDEX, {20'h0, pi});
      reg_rd(`ADDR_PAGE_DATA, d);
      `CHK(d, pg_m[pi])
      #1 `CHK(irq, |(est & m))
      @(posedge clk);
      reg_rd(`ADDR_INT_STATUS, d);
      `CHK(d, {29'h0, est})
      ab = ok && par && !hang;
    end
    reg_rd(`ADDR_SUP_SEL, d);
    `CHK(d, {29'h0, ss})
    tally_and_finish();
  end
endmodule
`default_nettype wire
